// ---- hw/power_mode_wakeup_control.sv ----
`timescale 1ns/10ps
module power_mode_wakeup_control
   import power_mode_pkg::*;
#(
   parameter int P0_W         = 8,
   parameter int P1_W         = 8,
   parameter bit WDT_ALWAYS_ON = 1'b0
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // Wishbone slave
   input  wire logic             cyc_i,
   input  wire logic             stb_i,
   input  wire logic             we_i,
   input  wire logic [ADR_W-1:0] adr_i,
   input  wire logic [3:0]       sel_i,
   input  wire logic [31:0]      dat_i,
   output logic [31:0]           dat_o,
   output logic                  ack_o,
   // Cpu core
   input  wire logic             instr_done_i,
   output logic                  cpu_run_o,
   output logic                  instr_strobe_o,
   // Wakeup pins and timers
   input  wire logic [P0_W-1:0]  port_zero_i,
   input  wire logic [P1_W-1:0]  port_one_i,
   input  wire logic             timer_zero_evt_i,
   input  wire logic             timer_counter_zero_evt_i,
   // Oscillators
   input  wire logic             high_osc_clk_i,
   input  wire logic             low_osc_clk_i,
   output logic                  high_osc_en_o,
   output logic                  low_osc_en_o,
   output logic                  slow_clock_o,
   output logic                  watchdog_en_o
);

   if (P0_W < 1 || P1_W < 1) begin : g_bad_width
      $error("port widths must be at least one");
   end

   // ----------------------------------------------------------------
   // Wakeup pin synchronisers and change detect
   // ----------------------------------------------------------------
   localparam int PW = P0_W + P1_W;

   logic [PW-1:0] pin_meta;
   logic [PW-1:0] pin_sync;
   logic [PW-1:0] pin_prev;
   logic          pin_ready;
   logic          pin_change;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_meta  <= '0;
         pin_sync  <= '0;
         pin_prev  <= '0;
         pin_ready <= 1'b0;
      end else begin
         pin_meta  <= {port_one_i, port_zero_i};
         pin_sync  <= pin_meta;
         pin_prev  <= pin_sync;
         pin_ready <= 1'b1;
      end
   end

   // Both ports count, any edge; compare opens one cycle after reset, while prev still holds the reset zeros
   assign pin_change = pin_ready & (|(pin_sync ^ pin_prev));

   // ----------------------------------------------------------------
   // Oscillator tick counters
   // ----------------------------------------------------------------
   pm_state_e state;
   logic      hosc_edge;
   logic      stab_done;
   logic      losc_cpu_tick;

   tick_counter #(
      .LIMIT  (STAB_HOSC_CLOCKS),
      .RELOAD (1'b0)
   ) u_stab (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .tick_i (high_osc_clk_i),
      .en_i   (state == ST_WAKE),
      .edge_o (hosc_edge),
      .done_o (stab_done)
   );

   tick_counter #(
      .LIMIT  (LOSC_CPU_DIV),
      .RELOAD (1'b1)
   ) u_losc_div (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .tick_i (low_osc_clk_i),
      .en_i   (state == ST_SLOW),
      .edge_o (),
      .done_o (losc_cpu_tick)
   );

   // ----------------------------------------------------------------
   // Wishbone slave
   // ----------------------------------------------------------------
   osc_ctrl_s   ctrl;
   wake_cfg_s   wcfg;
   logic [1:0]  pend_mode;
   logic        pend_valid;
   logic        timer_woke;
   logic [31:0] next_dat;
   logic        next_ack;
   logic        wr_take;

   // A write lands on the edge that samples ack high
   assign wr_take = ack_o & cyc_i & stb_i & we_i & sel_i[0];

   always_comb begin
      next_ack = cyc_i & stb_i & ~ack_o;
      next_dat = 32'h0;
      unique case (adr_i)
         ADDR_CTRL: begin
            next_dat[MODE_MSB:MODE_LSB]  = ctrl.cpu_mode;
            next_dat[SLOW_SEL_BIT]       = ctrl.slow_clock_select;
            next_dat[HIGH_OSC_STOP_BIT]  = ctrl.high_osc_stop;
         end
         ADDR_WAKE_CFG: begin
            next_dat[TZ_EN_BIT]    = wcfg.timer_zero_enable;
            next_dat[TC_GREEN_BIT] = wcfg.timer_counter_green_enable;
         end
         ADDR_STATUS: begin
            next_dat[STATE_MSB:STATE_LSB] = state;
            next_dat[PEND_BIT]            = pend_valid;
            next_dat[TIMER_WAKE_BIT]      = timer_woke;
         end
         default: begin
            next_dat = 32'h0;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0;
      end else begin
         ack_o <= next_ack;
         dat_o <= next_dat;
      end
   end

   // ----------------------------------------------------------------
   // Mode state machine and control bits
   // ----------------------------------------------------------------
   pm_state_e  next_state;
   osc_ctrl_s  next_ctrl;
   wake_cfg_s  next_wcfg;
   logic [1:0] next_pend_mode;
   logic       next_pend_valid;
   logic       green_from_slow;
   logic       next_green_from_slow;
   logic       next_timer_woke;
   logic       timer_wake;
   logic [1:0] wr_mode;

   assign wr_mode    = dat_i[MODE_MSB:MODE_LSB];
   assign timer_wake = (wcfg.timer_zero_enable & timer_zero_evt_i)
                     | (wcfg.timer_counter_green_enable & timer_counter_zero_evt_i);

   always_comb begin
      next_state           = state;
      next_ctrl            = ctrl;
      next_wcfg            = wcfg;
      next_pend_mode       = pend_mode;
      next_pend_valid      = pend_valid;
      next_green_from_slow = green_from_slow;
      next_timer_woke      = timer_woke;

      unique case (state)
         ST_NORMAL, ST_SLOW: begin
            // Mode change waits for the writing instruction to retire
            if (pend_valid && instr_done_i) begin
               next_pend_valid    = 1'b0;
               next_ctrl.cpu_mode = pend_mode;
               if (pend_mode == CPU_MODE_SLEEP) begin
                  next_state = ST_SLEEP;
               end else if (pend_mode == CPU_MODE_GREEN) begin
                  next_state           = ST_GREEN;
                  next_green_from_slow = (state == ST_SLOW);
               end
            end
            if (next_state == state) begin
               if (state == ST_NORMAL && ctrl.slow_clock_select) begin
                  next_state = ST_SLOW;
               end else if (state == ST_SLOW && !ctrl.slow_clock_select
                            && !ctrl.high_osc_stop) begin
                  // A stopped oscillator keeps the system slow
                  next_state = ST_NORMAL;
               end
            end
         end
         ST_GREEN: begin
            // Pin change or enabled timer; reset is the synchronous clear
            if (pin_change || timer_wake) begin
               next_state         = green_from_slow ? ST_SLOW : ST_NORMAL;
               next_ctrl.cpu_mode = CPU_MODE_NORMAL;
               next_timer_woke    = timer_wake & ~pin_change;
            end
         end
         ST_SLEEP: begin
            // Timers are ignored here on purpose
            if (pin_change) begin
               next_state                   = ST_WAKE;
               next_ctrl.cpu_mode           = CPU_MODE_NORMAL;
               next_ctrl.slow_clock_select  = 1'b0;
               next_ctrl.high_osc_stop      = 1'b0;
               next_timer_woke              = 1'b0;
            end
         end
         ST_WAKE: begin
            if (stab_done) begin
               next_state = ST_NORMAL;
            end
         end
      endcase

      // Register writes; a new write beats an apply in the same cycle
      if (wr_take && adr_i == ADDR_CTRL) begin
         next_ctrl.slow_clock_select = dat_i[SLOW_SEL_BIT];
         next_ctrl.high_osc_stop     = dat_i[HIGH_OSC_STOP_BIT];
         if (wr_mode != CPU_MODE_RESERVED && wr_mode != ctrl.cpu_mode) begin
            next_pend_mode  = wr_mode;
            next_pend_valid = 1'b1;
         end
      end
      if (wr_take && adr_i == ADDR_WAKE_CFG) begin
         next_wcfg.timer_zero_enable          = dat_i[TZ_EN_BIT];
         next_wcfg.timer_counter_green_enable = dat_i[TC_GREEN_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state           <= ST_NORMAL;
         ctrl            <= OSC_CTRL_RESET;
         wcfg            <= WAKE_CFG_RESET;
         pend_mode       <= CPU_MODE_NORMAL;
         pend_valid      <= 1'b0;
         green_from_slow <= 1'b0;
         timer_woke      <= 1'b0;
      end else begin
         state           <= next_state;
         ctrl            <= next_ctrl;
         wcfg            <= next_wcfg;
         pend_mode       <= next_pend_mode;
         pend_valid      <= next_pend_valid;
         green_from_slow <= next_green_from_slow;
         timer_woke      <= next_timer_woke;
      end
   end

   // ----------------------------------------------------------------
   // Clock and execution outputs
   // ----------------------------------------------------------------
   logic next_high_en;
   logic next_low_en;
   logic next_slow_clk;
   logic next_run;
   logic next_strobe;

   always_comb begin
      next_high_en  = 1'b1;
      next_low_en   = 1'b1;
      next_slow_clk = 1'b0;
      next_run      = 1'b0;
      next_strobe   = 1'b0;
      unique case (next_state)
         ST_NORMAL: begin
            next_run    = 1'b1;
            next_strobe = hosc_edge;
         end
         ST_SLOW: begin
            next_high_en  = ~next_ctrl.high_osc_stop;
            next_slow_clk = 1'b1;
            next_run      = 1'b1;
            next_strobe   = losc_cpu_tick;
         end
         ST_GREEN: begin
            next_high_en  = ~next_ctrl.high_osc_stop;
            next_slow_clk = next_green_from_slow;
         end
         ST_SLEEP: begin
            next_high_en = 1'b0;
            next_low_en  = 1'b0;
         end
         ST_WAKE: begin
            next_low_en = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         high_osc_en_o  <= 1'b1;
         low_osc_en_o   <= 1'b1;
         slow_clock_o   <= 1'b0;
         cpu_run_o      <= 1'b1;
         instr_strobe_o <= 1'b0;
         watchdog_en_o  <= WDT_ALWAYS_ON;
      end else begin
         high_osc_en_o  <= next_high_en;
         low_osc_en_o   <= next_low_en;
         slow_clock_o   <= next_slow_clk;
         cpu_run_o      <= next_run;
         instr_strobe_o <= next_strobe;
         // Build option only, never the state
         watchdog_en_o  <= WDT_ALWAYS_ON;
      end
   end

endmodule

// ---- hw/power_mode_pkg.sv ----
package power_mode_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses, one word each)
   // ----------------------------------------------------------------
   localparam int         ADR_W          = 4;
   localparam logic [3:0] ADDR_CTRL      = 4'h0;
   localparam logic [3:0] ADDR_WAKE_CFG  = 4'h4;
   localparam logic [3:0] ADDR_STATUS    = 4'h8;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int HIGH_OSC_STOP_BIT  = 1;
   localparam int SLOW_SEL_BIT       = 2;
   localparam int MODE_LSB           = 3;
   localparam int MODE_MSB           = 4;
   localparam int TZ_EN_BIT          = 0;
   localparam int TC_GREEN_BIT       = 1;
   localparam int STATE_LSB          = 0;
   localparam int STATE_MSB          = 2;
   localparam int PEND_BIT           = 3;
   localparam int TIMER_WAKE_BIT     = 4;

   // ----------------------------------------------------------------
   // Cpu mode field codes
   // ----------------------------------------------------------------
   localparam logic [1:0] CPU_MODE_NORMAL   = 2'h0;
   localparam logic [1:0] CPU_MODE_SLEEP    = 2'h1;
   localparam logic [1:0] CPU_MODE_GREEN    = 2'h2;
   localparam logic [1:0] CPU_MODE_RESERVED = 2'h3;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int STAB_HOSC_CLOCKS = 2048;
   localparam int LOSC_CPU_DIV     = 4;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_NORMAL,
      ST_SLOW,
      ST_GREEN,
      ST_SLEEP,
      ST_WAKE
   } pm_state_e;

   typedef struct packed {
      logic [1:0] cpu_mode;
      logic       slow_clock_select;
      logic       high_osc_stop;
   } osc_ctrl_s;

   typedef struct packed {
      logic timer_zero_enable;
      logic timer_counter_green_enable;
   } wake_cfg_s;

   localparam osc_ctrl_s OSC_CTRL_RESET = '{CPU_MODE_NORMAL, 1'b0, 1'b0};
   localparam wake_cfg_s WAKE_CFG_RESET = '{1'b0, 1'b0};

endpackage

// ---- hw/tick_counter.sv ----
`timescale 1ns/10ps
module tick_counter #(
   parameter int LIMIT  = 4,
   parameter bit RELOAD = 1'b1
) (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Pin tick and control
   input  wire logic tick_i,
   input  wire logic en_i,
   // Results
   output logic      edge_o,
   output logic      done_o
);

   localparam int CW = $clog2(LIMIT + 1);
   localparam logic [CW-1:0] LAST = CW'(LIMIT);
   localparam logic [CW-1:0] ONE  = CW'(1);

   if (LIMIT < 1) begin : g_bad_limit
      $error("tick_counter LIMIT must be at least one");
   end

   logic          meta;
   logic          sync;
   logic          prev;
   logic [CW-1:0] cnt;
   logic [CW-1:0] next_cnt;
   logic          next_done;
   logic          rise;

   assign rise   = sync & ~prev;
   assign edge_o = rise;

   always_comb begin
      next_cnt  = cnt;
      next_done = 1'b0;
      if (!en_i) begin
         next_cnt = '0;
      end else if (rise) begin
         if (cnt + ONE == LAST) begin
            next_done = 1'b1;
            next_cnt  = RELOAD ? '0 : LAST;
         end else if (cnt != LAST) begin
            next_cnt = cnt + ONE;
         end
      end
      // Hold mode keeps done up until the enable drops
      if (!RELOAD && en_i && cnt == LAST) begin
         next_done = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta   <= 1'b0;
         sync   <= 1'b0;
         prev   <= 1'b0;
         cnt    <= '0;
         done_o <= 1'b0;
      end else begin
         meta   <= tick_i;
         sync   <= meta;
         prev   <= sync;
         cnt    <= next_cnt;
         done_o <= next_done;
      end
   end

endmodule

// ---- testbench/power_mode_properties.sv ----
`timescale 1ns/10ps
module power_mode_properties
   import power_mode_pkg::*;
#(
   parameter int P0_W          = 8,
   parameter int P1_W          = 8,
   parameter bit WDT_ALWAYS_ON = 1'b0
) (
   // Clock, reset, bus
   input wire logic            clk_i,
   input wire logic            rst_i,
   input wire logic            cyc_i,
   input wire logic            stb_i,
   input wire logic            ack_o,
   // Core, pins, oscillators
   input wire logic            cpu_run_o,
   input wire logic            instr_strobe_o,
   input wire logic [P0_W-1:0] port_zero_i,
   input wire logic [P1_W-1:0] port_one_i,
   input wire logic            high_osc_clk_i,
   input wire logic            high_osc_en_o,
   input wire logic            low_osc_en_o,
   input wire logic            slow_clock_o,
   input wire logic            watchdog_en_o
);
   // ----------------------------------------------------------------
   // Raw oscillator edges seen since sleep; leads the design's sync
   // ----------------------------------------------------------------
   logic        hp, next_hp, was_sleep, next_was_sleep;
   logic [12:0] edges, next_edges;

   always_comb begin
      next_hp = high_osc_clk_i;
      next_was_sleep = was_sleep;
      next_edges = edges;
      if (!low_osc_en_o && !high_osc_en_o) begin
         next_was_sleep = 1'b1;
         next_edges = 13'h0;
      end else if (cpu_run_o) begin
         next_was_sleep = 1'b0;
      end else if (high_osc_clk_i && !hp && edges != 13'h1fff) begin
         next_edges = edges + 13'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hp <= 1'b0;
         was_sleep <= 1'b0;
         edges <= 13'h0;
      end else begin
         hp <= next_hp;
         was_sleep <= next_was_sleep;
         edges <= next_edges;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   reset_state_a: assert property ($fell(rst_i) |-> cpu_run_o && high_osc_en_o
      && low_osc_en_o && !slow_clock_o) else $error("bad state after reset");
   ack_timing_a: assert property ($rose(cyc_i && stb_i) |=> ack_o)
      else $error("ack not one cycle after request");
   ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held");
   sleep_osc_a: assert property ($fell(low_osc_en_o) |-> !high_osc_en_o && !cpu_run_o)
      else $error("sleep left an oscillator or cpu running");
   halted_strobe_a: assert property ((!cpu_run_o)[*3] |-> !instr_strobe_o)
      else $error("instruction strobe while halted");
   wdt_fixed_a: assert property (1'b1 |-> watchdog_en_o == WDT_ALWAYS_ON)
      else $error("watchdog enable follows state");
   sleep_hold_a: assert property ((!low_osc_en_o && !high_osc_en_o && $stable(port_zero_i)
      && $stable(port_one_i))[*4] |=> !high_osc_en_o) else $error("sleep left without pin");
   wake_count_a: assert property ($rose(cpu_run_o) && was_sleep |-> edges >= 13'h800
      && edges <= 13'h803 && high_osc_en_o && !slow_clock_o) else $error("wake count wrong");
endmodule

bind power_mode_wakeup_control power_mode_properties #(
   .P0_W(P0_W), .P1_W(P1_W), .WDT_ALWAYS_ON(WDT_ALWAYS_ON)
) chk_u (
   .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
   .cpu_run_o(cpu_run_o), .instr_strobe_o(instr_strobe_o), .port_zero_i(port_zero_i),
   .port_one_i(port_one_i), .high_osc_clk_i(high_osc_clk_i), .high_osc_en_o(high_osc_en_o),
   .low_osc_en_o(low_osc_en_o), .slow_clock_o(slow_clock_o), .watchdog_en_o(watchdog_en_o)
);

// ---- testbench/pm_far_side.sv ----
`timescale 1ns/10ps
module pm_far_side (
   // Clock
   input  wire logic clk_i,
   // From the block, and hold from the testbench
   input  wire logic hold_i,
   input  wire logic instr_strobe_i,
   input  wire logic high_en_i,
   input  wire logic low_en_i,
   // To the block
   output logic      high_clk_o,
   output logic      low_clk_o,
   output logic      instr_done_o
);
   // Oscillators stand still while disabled; phase kept off clk edges
   initial begin
      high_clk_o = 1'b0;
      #37;
      forever begin
         #100;
         high_clk_o = high_en_i ? ~high_clk_o : 1'b0;
      end
   end

   initial begin
      low_clk_o = 1'b0;
      #61;
      forever begin
         #200;
         low_clk_o = low_en_i ? ~low_clk_o : 1'b0;
      end
   end

   // Core retires one instruction per strobe; hold stalls it
   initial instr_done_o = 1'b0;
   always @(posedge clk_i) begin
      instr_done_o <= instr_strobe_i && !hold_i;
   end
endmodule

// ---- testbench/power_mode_wakeup_control_tb.sv ----
`timescale 1ns/10ps
module power_mode_wakeup_control_tb;
   import power_mode_pkg::*;
   logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, hold;
   logic [3:0]  adr_i, sel_i;
   logic [31:0] dat_i, dat_o, rd;
   logic [7:0]  port_zero_i, port_one_i;
   logic        tz_evt, tc_evt, instr_done_i, cpu_run_o, instr_strobe_o;
   logic        high_osc_clk_i, low_osc_clk_i, high_osc_en_o, low_osc_en_o;
   logic        slow_clock_o, watchdog_en_o;
   int          errors, checks, n;

   power_mode_wakeup_control dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .instr_done_i(instr_done_i), .cpu_run_o(cpu_run_o), .instr_strobe_o(instr_strobe_o),
      .port_zero_i(port_zero_i), .port_one_i(port_one_i), .timer_zero_evt_i(tz_evt),
      .timer_counter_zero_evt_i(tc_evt), .high_osc_clk_i(high_osc_clk_i),
      .low_osc_clk_i(low_osc_clk_i), .high_osc_en_o(high_osc_en_o),
      .low_osc_en_o(low_osc_en_o), .slow_clock_o(slow_clock_o), .watchdog_en_o(watchdog_en_o)
   );

   pm_far_side far_u (
      .clk_i(clk_i), .hold_i(hold), .instr_strobe_i(instr_strobe_o),
      .high_en_i(high_osc_en_o), .low_en_i(low_osc_en_o), .high_clk_o(high_osc_clk_i),
      .low_clk_o(low_osc_clk_i), .instr_done_o(instr_done_i)
   );

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      do @(posedge clk_i); while (ack_o !== 1'b1);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask

   task rdchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      check(rd & m, e);
   endtask

   task idle(input int c);
      repeat (c) @(posedge clk_i);
   endtask

   task pulse(input int which);
      @(posedge clk_i);
      tz_evt <= (which == 0);
      tc_evt <= (which == 1);
      @(posedge clk_i);
      tz_evt <= 1'b0;
      tc_evt <= 1'b0;
   endtask

   task wrap_up;
      if (errors == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   // Whole run is about 9k cycles
   initial begin
      #3000000;
      errors++;
      wrap_up;
   end

   initial begin
      rst_i = 1'b1;
      {cyc_i, stb_i, we_i, hold, tz_evt, tc_evt} = 6'h0;
      adr_i = 4'h0;
      sel_i = 4'hf;
      dat_i = 32'h0;
      port_zero_i = 8'hff;
      port_one_i = 8'hff;
      errors = 0;
      checks = 0;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      idle(3);
      rdchk(ADDR_CTRL, 32'hffffffff, 32'h0);
      rdchk(ADDR_WAKE_CFG, 32'hffffffff, 32'h0);
      rdchk(ADDR_STATUS, 32'hffffffff, 32'h0);
      rdchk(4'hc, 32'hffffffff, 32'h0);
      check(32'(watchdog_en_o), 32'h0);
      bus(1'b1, ADDR_CTRL, 32'h4);
      idle(10);
      check(32'(slow_clock_o), 32'h1);
      rdchk(ADDR_STATUS, 32'h7, 32'h1);
      n = 0;
      repeat (320) begin
         @(posedge clk_i);
         if (instr_strobe_o === 1'b1) n++;
      end
      check(32'(n >= 9 && n <= 11), 32'h1);
      bus(1'b1, ADDR_CTRL, 32'h6);
      idle(10);
      check(32'({high_osc_en_o, low_osc_en_o, cpu_run_o}), 32'h3);
      bus(1'b1, ADDR_CTRL, 32'h4);
      idle(40);
      bus(1'b1, ADDR_CTRL, 32'h0);
      idle(10);
      rdchk(ADDR_STATUS, 32'h7, 32'h0);
      check(32'(slow_clock_o), 32'h0);
      bus(1'b1, ADDR_CTRL, 32'h18);
      idle(10);
      rdchk(ADDR_CTRL, 32'h18, 32'h0);
      hold <= 1'b1;
      bus(1'b1, ADDR_CTRL, 32'h10);
      rdchk(ADDR_STATUS, 32'hf, 32'h8);
      hold <= 1'b0;
      idle(20);
      rdchk(ADDR_STATUS, 32'h7, 32'h2);
      check(32'(cpu_run_o), 32'h0);
      pulse(0);
      pulse(1);
      idle(10);
      rdchk(ADDR_STATUS, 32'h7, 32'h2);
      port_one_i[3] <= 1'b0;
      idle(10);
      rdchk(ADDR_STATUS, 32'h1f, 32'h0);
      rdchk(ADDR_CTRL, 32'h18, 32'h0);
      // Green entered from slow must come back to slow
      for (int i = 0; i < 2; i++) begin
         bus(1'b1, ADDR_WAKE_CFG, 32'(i + 1));
         bus(1'b1, ADDR_CTRL, 32'h4);
         bus(1'b1, ADDR_CTRL, 32'h14);
         // Slow core retires one instruction per 32 cycles here
         idle(60);
         rdchk(ADDR_STATUS, 32'h7, 32'h2);
         pulse(i);
         idle(10);
         rdchk(ADDR_STATUS, 32'h1f, 32'h11);
      end
      bus(1'b1, ADDR_CTRL, 32'hc);
      idle(60);
      rdchk(ADDR_STATUS, 32'h7, 32'h3);
      check(32'({cpu_run_o, high_osc_en_o, low_osc_en_o}), 32'h0);
      pulse(0);
      pulse(1);
      idle(10);
      rdchk(ADDR_STATUS, 32'h7, 32'h3);
      port_zero_i[0] <= 1'b0;
      n = 0;
      while (cpu_run_o !== 1'b1 && n < 12000) begin
         @(posedge clk_i);
         n++;
      end
      check(32'(n >= 8192 && n < 12000), 32'h1);
      rdchk(ADDR_STATUS, 32'h7, 32'h0);
      rdchk(ADDR_CTRL, 32'h1e, 32'h0);
      wrap_up;
   end
endmodule
